/* File: shared/sleep_pm_params.svh */
`ifndef SLEEP_PM_PARAMS_SVH
`define SLEEP_PM_PARAMS_SVH

// Register byte offsets on the plain register port
`define PM_REG_CTRL         8'h00
`define PM_REG_MGMT_EN      8'h04
`define PM_REG_EVT_STS      8'h08
`define PM_REG_EVT_EN       8'h0c
`define PM_REG_SCI_CFG      8'h10
`define PM_REG_STATE        8'h14

// Control register fields
`define PM_CTRL_SLEEP_GO    0
`define PM_CTRL_MIN_EN      1
`define PM_CTRL_SW_EVT      2
`define PM_CTRL_TYPE_LO     4
`define PM_CTRL_TYPE_HI     5

// Sleep type codes; both land in the same sleep state
`define PM_SLP_TYPE_S4      2'h1
`define PM_SLP_TYPE_S5      2'h2

// Management enable register fields
`define PM_MGMT_GLOBAL_EN   0
`define PM_MGMT_EOI         1
`define PM_MGMT_SCI_ROUTE   2

// Event status and enable bit positions
`define PM_EVT_PWRBTN       0
`define PM_EVT_BATLOW       1
`define PM_EVT_SW           2

// SCI configuration fields
`define PM_SCI_SEL_HI       4
`define PM_SCI_APIC         8
`define PM_SCI_SHARED       9

// State register fields
`define PM_ST_ASLEEP        0
`define PM_ST_MIN_BUSY      1
`define PM_ST_SHORT         2
`define PM_ST_MGMT_ACT      3
`define PM_ST_SCI_LEVEL     4
`define PM_ST_PWR_GOOD      5
`define PM_ST_BATLOW        6
`define PM_ST_SEL_LEGAL     7

// Reset values
`define PM_EOI_RESET        1'b1
`define PM_SCI_SEL_RESET    5'h09
`define PM_GLOBAL_EN_RESET  1'b0

// Timing
`define PM_CLK_MHZ          200
`define PM_S4_MIN_TIME_US   1000

// Virtual wire message code for a management interrupt (arbitrary value)
`define PM_VW_MGMT_CODE     8'h01

`endif

/* File: shared/sleep_pm_pkg.sv */
`default_nettype none

package sleep_pm_pkg;

    // Power state, one-hot
    typedef enum logic [1:0] {
        PM_ON    = 2'b01,
        PM_SLEEP = 2'b10
    } pm_state_e;

    // One bit per event source
    typedef logic [2:0] pm_evt_t;

endpackage

`default_nettype wire

/* File: core/pm_min_timer.sv */
`timescale 1ns/1ps
`default_nettype none

module pm_min_timer #(
    parameter int unsigned CYCLES = 32'd200000
) (
    input  wire logic mclk,
    input  wire logic srst,
    input  wire logic ce,
    input  wire logic start,
    input  wire logic run,
    output logic      busy
);

    logic [31:0] count;

    // Counts up from the entry into sleep; stops once the minimum has passed
    always_ff @(posedge mclk) begin
        if (srst) begin
            count <= 32'h0;
            busy  <= 1'b0;
        end else if (ce) begin
            if (start) begin
                count <= 32'h1;
                busy  <= (CYCLES > 32'd1);
            end else if (!run) begin
                busy  <= 1'b0;
            end else if (busy) begin
                count <= count + 32'h1;
                busy  <= (count + 32'h1) < CYCLES;
            end
        end
    end

endmodule

`default_nettype wire

/* File: core/sleep_power_and_smi_sci_gen.sv */
// Contract
// - One sleep-S4 output covers S4 and S5; no separate S5 output exists.
// - Entering S4/S5 asserts sleep-S4 so supplies may drop, memory included.
// - Minimum-assertion feature forces full DRAM power cycle or flags too-short off time.
// - Core power-good low asserts platform reset without waiting for a clock.
// - Battery low blocks wake from S4 and S5.
// - Battery low asserting in S0 raises a management interrupt.
// - Enabled event with end-of-interrupt set clears it and signals interrupt.
// - Management interrupts go out as virtual wire messages, not a pin.
// - After a message, pending events are ignored until end-of-interrupt is set.
// - Setting end-of-interrupt with events still active sends another message.
// - SCI is driven as a level, never a pulse.
// - Without APIC the SCI goes to legacy line 9, 10 or 11.
// - With APIC the SCI may go to lines 9 to 11 or 20 to 23.
// - SCI polarity follows whether the chosen line is shared with PCI.
// - SCI stays asserted while any enabled source is active.
// - Each source has its own status flag and enable bit.
// - Global management enable and SCI route enable steer events.
// - Power button is no wake event while sleep-S4 is being stretched.
`timescale 1ns/1ps
`default_nettype none

`include "sleep_pm_params.svh"

module sleep_power_and_smi_sci_gen
    import sleep_pm_pkg::*;
#(
    parameter int unsigned S4_MIN_CYCLES = `PM_S4_MIN_TIME_US * `PM_CLK_MHZ
) (
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic        ce,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [31:0] regRdData,
    input  wire logic        core_power_good,
    input  wire logic        battery_low_in_n,
    input  wire logic        powerButtonPress,
    output logic             sleep_s4_out_n,
    output logic             suspend_powerdown_ack,
    output logic             platform_reset_out_n,
    output logic             vwMsgValid,
    output logic      [7:0]  vwMsgCode,
    input  wire logic        vwMsgReady,
    output logic      [23:0] sciIrqLines
);

    pm_state_e   state;
    pm_state_e   next_state;
    pm_evt_t     evtSts;
    pm_evt_t     evtEn;
    pm_evt_t     evtSet;
    pm_evt_t     evtClr;
    logic        s4MinAssertEnable;
    logic [1:0]  sleepType;
    logic        globalMgmtIrqEnable;
    logic        endOfMgmtIrq;
    logic        sciRouteEnable;
    logic [4:0]  sciSel;
    logic        sciApic;
    logic        sciShared;
    logic        s4AssertShort;
    logic        batLowPrev;
    logic        minBusy;
    logic        wrCtrl;
    logic        wrMgmt;
    logic        wrSts;
    logic        wrEn;
    logic        wrSci;
    logic        wrState;
    logic        anyActive;
    logic        mgmtActive;
    logic        sciLevel;
    logic        sleepGo;
    logic        wakeReq;
    logic        issueMsg;

    // Address match, shared by every write decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // Which lines the SCI may sit on in the current controller mode
    function automatic logic sciLegal(input logic [4:0] sel, input logic apic);
        logic legacy;
        logic upper;
        legacy   = (sel >= 5'h09) && (sel <= 5'h0b);
        upper    = (sel >= 5'h14) && (sel <= 5'h17);
        sciLegal = legacy || (apic && upper);
    endfunction

    assign wrCtrl  = regWr && hit(regAddr, `PM_REG_CTRL);
    assign wrMgmt  = regWr && hit(regAddr, `PM_REG_MGMT_EN);
    assign wrSts   = regWr && hit(regAddr, `PM_REG_EVT_STS);
    assign wrEn    = regWr && hit(regAddr, `PM_REG_EVT_EN);
    assign wrSci   = regWr && hit(regAddr, `PM_REG_SCI_CFG);
    assign wrState = regWr && hit(regAddr, `PM_REG_STATE);

    // Steering of enabled events; the SCI route takes precedence over the global enable
    assign anyActive  = |(evtSts & evtEn);
    assign mgmtActive = anyActive && !sciRouteEnable && globalMgmtIrqEnable;
    assign sciLevel   = anyActive && sciRouteEnable;

    // A message leaves only when the end-of-interrupt bit allows it
    assign issueMsg = mgmtActive && endOfMgmtIrq && !vwMsgValid;

    // Both S4 and S5 requests mean the same sleep state
    assign sleepGo = wrCtrl && regWrData[`PM_CTRL_SLEEP_GO];

    // Wake needs enough battery and must not cut the stretched off time short
    assign wakeReq = powerButtonPress && battery_low_in_n
                     && !(s4MinAssertEnable && minBusy);

    // Next power state
    always_comb begin
        next_state = state;
        unique case (state)
            PM_ON: begin
                if (sleepGo) begin
                    next_state = PM_SLEEP;
                end
            end
            PM_SLEEP: begin
                if (wakeReq) begin
                    next_state = PM_ON;
                end
            end
        endcase
    end

    // Event sources: set beats a same-cycle software clear
    always_comb begin
        evtSet = '0;
        evtSet[`PM_EVT_PWRBTN] = powerButtonPress && (state == PM_ON);
        evtSet[`PM_EVT_BATLOW] = batLowPrev && !battery_low_in_n && (state == PM_ON);
        evtSet[`PM_EVT_SW]     = wrCtrl && regWrData[`PM_CTRL_SW_EVT];
        evtClr = wrSts ? regWrData[2:0] : '0;
    end

    // Minimum off-time counter, restarted on every sleep entry
    pm_min_timer #(
        .CYCLES (S4_MIN_CYCLES)
    ) u_min_timer (
        .mclk  (mclk),
        .srst  (srst),
        .ce    (ce),
        .start (state == PM_ON && next_state == PM_SLEEP),
        .run   (state == PM_SLEEP),
        .busy  (minBusy)
    );

    // Power state and the outputs that follow it
    always_ff @(posedge mclk) begin
        if (srst) begin
            state                 <= PM_ON;
            sleep_s4_out_n        <= 1'b1;
            suspend_powerdown_ack <= 1'b0;
        end else if (ce) begin
            state                 <= next_state;
            sleep_s4_out_n        <= (next_state == PM_ON);
            suspend_powerdown_ack <= (next_state == PM_SLEEP);
        end
    end

    // Platform reset drops at once with power-good; release waits for a clock
    always_ff @(posedge mclk or negedge core_power_good) begin
        if (!core_power_good) begin
            platform_reset_out_n <= 1'b0;
        end else if (srst) begin
            platform_reset_out_n <= 1'b0;
        end else if (ce) begin
            platform_reset_out_n <= (next_state == PM_ON);
        end
    end

    // Battery-low edge detect; input is already synchronous
    always_ff @(posedge mclk) begin
        if (srst) begin
            batLowPrev <= 1'b1;
        end else if (ce) begin
            batLowPrev <= battery_low_in_n;
        end
    end

    // Status flags, one per source
    always_ff @(posedge mclk) begin
        if (srst) begin
            evtSts <= '0;
        end else if (ce) begin
            evtSts <= (evtSts & ~evtClr) | evtSet;
        end
    end

    // Enables and control fields
    always_ff @(posedge mclk) begin
        if (srst) begin
            evtEn               <= '0;
            s4MinAssertEnable   <= 1'b0;
            sleepType           <= `PM_SLP_TYPE_S4;
            globalMgmtIrqEnable <= `PM_GLOBAL_EN_RESET;
            sciRouteEnable      <= 1'b0;
        end else if (ce) begin
            if (wrEn) begin
                evtEn <= regWrData[2:0];
            end
            if (wrCtrl) begin
                s4MinAssertEnable <= regWrData[`PM_CTRL_MIN_EN];
            end
            if (sleepGo) begin
                sleepType <= regWrData[`PM_CTRL_TYPE_HI:`PM_CTRL_TYPE_LO];
            end
            if (wrMgmt) begin
                globalMgmtIrqEnable <= regWrData[`PM_MGMT_GLOBAL_EN];
                sciRouteEnable      <= regWrData[`PM_MGMT_SCI_ROUTE];
            end
        end
    end

    // End-of-interrupt: software may only set it, hardware only clears it
    always_ff @(posedge mclk) begin
        if (srst) begin
            endOfMgmtIrq <= `PM_EOI_RESET;
        end else if (ce) begin
            if (issueMsg) begin
                endOfMgmtIrq <= 1'b0;
            end else if (wrMgmt && regWrData[`PM_MGMT_EOI]) begin
                endOfMgmtIrq <= 1'b1;
            end
        end
    end

    // Virtual wire message, held until the core side accepts it
    always_ff @(posedge mclk) begin
        if (srst) begin
            vwMsgValid <= 1'b0;
            vwMsgCode  <= 8'h00;
        end else if (ce) begin
            if (issueMsg) begin
                vwMsgValid <= 1'b1;
                vwMsgCode  <= `PM_VW_MGMT_CODE;
            end else if (vwMsgReady) begin
                vwMsgValid <= 1'b0;
                vwMsgCode  <= 8'h00;
            end
        end
    end

    // SCI routing; a shared line idles high so it can be wire-combined
    always_ff @(posedge mclk) begin
        if (srst) begin
            sciSel    <= `PM_SCI_SEL_RESET;
            sciApic   <= 1'b0;
            sciShared <= 1'b0;
        end else if (ce && wrSci) begin
            sciSel    <= regWrData[`PM_SCI_SEL_HI:0];
            sciApic   <= regWrData[`PM_SCI_APIC];
            sciShared <= regWrData[`PM_SCI_SHARED];
        end
    end

    // Only the selected legal line carries the level; others stay low
    always_ff @(posedge mclk) begin
        if (srst) begin
            sciIrqLines <= 24'h000000;
        end else if (ce) begin
            for (int i = 0; i < 24; i++) begin
                if (sciLegal(sciSel, sciApic) && (sciSel == 5'(i))) begin
                    sciIrqLines[i] <= sciLevel ^ sciShared;
                end else begin
                    sciIrqLines[i] <= 1'b0;
                end
            end
        end
    end

    // Too-short off time is flagged when stretching was not enforced
    always_ff @(posedge mclk) begin
        if (srst) begin
            s4AssertShort <= 1'b0;
        end else if (ce) begin
            if (state == PM_SLEEP && wakeReq && minBusy) begin
                s4AssertShort <= 1'b1;
            end else if (wrState && regWrData[`PM_ST_SHORT]) begin
                s4AssertShort <= 1'b0;
            end
        end
    end

    // Read data live for exactly one cycle after the strobe
    always_ff @(posedge mclk) begin
        if (srst) begin
            regRdData <= 32'h0;
        end else if (ce) begin
            regRdData <= 32'h0;
            if (regRd) begin
                unique case (regAddr)
                    `PM_REG_CTRL: begin
                        regRdData[`PM_CTRL_MIN_EN]                    <= s4MinAssertEnable;
                        regRdData[`PM_CTRL_TYPE_HI:`PM_CTRL_TYPE_LO]  <= sleepType;
                    end
                    `PM_REG_MGMT_EN: begin
                        regRdData[`PM_MGMT_GLOBAL_EN] <= globalMgmtIrqEnable;
                        regRdData[`PM_MGMT_EOI]       <= endOfMgmtIrq;
                        regRdData[`PM_MGMT_SCI_ROUTE] <= sciRouteEnable;
                    end
                    `PM_REG_EVT_STS: regRdData[2:0] <= evtSts;
                    `PM_REG_EVT_EN:  regRdData[2:0] <= evtEn;
                    `PM_REG_SCI_CFG: begin
                        regRdData[`PM_SCI_SEL_HI:0] <= sciSel;
                        regRdData[`PM_SCI_APIC]     <= sciApic;
                        regRdData[`PM_SCI_SHARED]   <= sciShared;
                    end
                    `PM_REG_STATE: begin
                        regRdData[`PM_ST_ASLEEP]    <= (state == PM_SLEEP);
                        regRdData[`PM_ST_MIN_BUSY]  <= minBusy;
                        regRdData[`PM_ST_SHORT]     <= s4AssertShort;
                        regRdData[`PM_ST_MGMT_ACT]  <= mgmtActive;
                        regRdData[`PM_ST_SCI_LEVEL] <= sciLevel;
                        regRdData[`PM_ST_PWR_GOOD]  <= core_power_good;
                        regRdData[`PM_ST_BATLOW]    <= !battery_low_in_n;
                        regRdData[`PM_ST_SEL_LEGAL] <= sciLegal(sciSel, sciApic);
                    end
                    default: regRdData <= 32'h0;
                endcase
            end
        end
    end

endmodule

`default_nettype wire

/* File: tb/core_vw_model.sv */
`timescale 1ns/1ps
`default_nettype none

module core_vw_model (
    input  wire logic       mclk,
    input  wire logic       srst,
    input  wire logic [3:0] stallCycles,
    input  wire logic       vwMsgValid,
    input  wire logic [7:0] vwMsgCode,
    output logic            vwMsgReady,
    output logic      [7:0] msgCount,
    output logic      [7:0] lastCode
);
    logic [3:0] waitCnt;

    // Core takes a message only after its own stall; a slow core must not lose one
    always_ff @(posedge mclk) begin
        if (srst) begin
            vwMsgReady <= 1'b0;
            waitCnt    <= 4'h0;
            msgCount   <= 8'h00;
            lastCode   <= 8'h00;
        end else if (vwMsgValid && vwMsgReady) begin
            msgCount   <= msgCount + 8'h01;
            lastCode   <= vwMsgCode;
            vwMsgReady <= 1'b0;
            waitCnt    <= 4'h0;
        end else if (vwMsgValid) begin
            if (waitCnt == stallCycles) begin
                vwMsgReady <= 1'b1;
            end else begin
                waitCnt <= waitCnt + 4'h1;
            end
        end else begin
            vwMsgReady <= 1'b0;
            waitCnt    <= 4'h0;
        end
    end
endmodule

`default_nettype wire

/* File: tb/pm_checker_properties.sv */
`timescale 1ns/1ps
`default_nettype none

`include "sleep_pm_params.svh"

module pm_checker #(
    parameter int unsigned S4_MIN_CYCLES = 32'd200000
) (
    input wire logic        mclk,
    input wire logic        srst,
    input wire logic        ce,
    input wire logic [7:0]  regAddr,
    input wire logic [31:0] regWrData,
    input wire logic        regWr,
    input wire logic        regRd,
    input wire logic [31:0] regRdData,
    input wire logic        core_power_good,
    input wire logic        battery_low_in_n,
    input wire logic        powerButtonPress,
    input wire logic        sleep_s4_out_n,
    input wire logic        suspend_powerdown_ack,
    input wire logic        platform_reset_out_n,
    input wire logic        vwMsgValid,
    input wire logic [7:0]  vwMsgCode,
    input wire logic        vwMsgReady,
    input wire logic [23:0] sciIrqLines
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    a_pg_reset: assert property (!core_power_good |-> !platform_reset_out_n)
        else $error("platform reset released while power good low");
    a_sleep_ack: assert property (suspend_powerdown_ack == !sleep_s4_out_n)
        else $error("suspend ack disagrees with sleep output");
    a_sleep_rst: assert property (!sleep_s4_out_n |-> !platform_reset_out_n)
        else $error("platform reset released while asleep");
    a_batlow_nowake: assert property (!sleep_s4_out_n && !battery_low_in_n |=> !sleep_s4_out_n)
        else $error("woke while battery low");
    a_vw_hold: assert property (vwMsgValid && !vwMsgReady |=> vwMsgValid && $stable(vwMsgCode))
        else $error("message dropped before accept");
    a_vw_done: assert property (vwMsgValid && vwMsgReady |=> !vwMsgValid)
        else $error("message held after accept");
    a_vw_code: assert property (vwMsgCode == (vwMsgValid ? `PM_VW_MGMT_CODE : 8'h00))
        else $error("wrong message code");
    a_sci_one: assert property ($onehot0(sciIrqLines))
        else $error("SCI on more than one line");
    a_sci_legal: assert property (sciIrqLines[8:0] == 9'h0 && sciIrqLines[19:12] == 8'h0)
        else $error("SCI on an illegal line");
endmodule

bind sleep_power_and_smi_sci_gen pm_checker #(.S4_MIN_CYCLES(S4_MIN_CYCLES)) pm_checker_i (
    .mclk, .srst, .ce, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .core_power_good,
    .battery_low_in_n, .powerButtonPress, .sleep_s4_out_n, .suspend_powerdown_ack,
    .platform_reset_out_n, .vwMsgValid, .vwMsgCode, .vwMsgReady, .sciIrqLines
);

`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic        mclk, srst, ce, regWr, regRd, core_power_good, battery_low_in_n;
    logic        powerButtonPress, vwMsgReady, vwMsgValid;
    logic        sleep_s4_out_n, suspend_powerdown_ack, platform_reset_out_n;
    logic [7:0]  regAddr, vwMsgCode, msgCount, lastCode;
    logic [31:0] regWrData, regRdData, d;
    logic [23:0] sciIrqLines;
    logic [3:0]  stallCycles;
    int          n_fail, checked;

    sleep_power_and_smi_sci_gen #(.S4_MIN_CYCLES(20)) sleep_power_and_smi_sci_gen_i (
        .mclk, .srst, .ce, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .core_power_good,
        .battery_low_in_n, .powerButtonPress, .sleep_s4_out_n, .suspend_powerdown_ack,
        .platform_reset_out_n, .vwMsgValid, .vwMsgCode, .vwMsgReady, .sciIrqLines);
    core_vw_model core_vw_model_i (.mclk, .srst, .stallCycles, .vwMsgValid, .vwMsgCode,
        .vwMsgReady, .msgCount, .lastCode);

    // Clock, 5 ns period
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        regWr     <= 1'b1;
        regAddr   <= a;
        regWrData <= v;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRd <= 1'b0;
        #1 v = regRdData;
    endtask

    task automatic press();
        @(posedge mclk);
        powerButtonPress <= 1'b1;
        @(posedge mclk);
        powerButtonPress <= 1'b0;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // Bounded wait for the core model to have taken n messages
    task automatic expect_msgs(input logic [7:0] n);
        for (int i = 0; i < 30 && msgCount !== n; i++) @(posedge mclk);
        #1 chk({24'h0, msgCount}, {24'h0, n});
    endtask

    function automatic logic [31:0] pins();
        return {29'h0, sleep_s4_out_n, suspend_powerdown_ack, platform_reset_out_n};
    endfunction

    task automatic t_reset();
        settle(2);
        chk(pins(), 32'h5);
        chk({8'h0, sciIrqLines}, 32'h0);
        rd(8'h04, d);
        chk(d, 32'h2);
        rd(8'h40, d);
        chk(d, 32'h0);
    endtask

    // Board is taken to switch DRAM and suspend planes with the sleep output
    task automatic t_sleep();
        wr(8'h00, 32'h11);
        settle(2);
        chk(pins(), 32'h2);
        @(posedge mclk);
        battery_low_in_n <= 1'b0;
        press();
        settle(2);
        chk(pins(), 32'h2);
        battery_low_in_n <= 1'b1;
        press();
        settle(2);
        chk(pins(), 32'h5);
        rd(8'h14, d);
        chk({31'h0, d[2]}, 32'h1);
        wr(8'h00, 32'h23);
        settle(2);
        chk(pins(), 32'h2);
        press();
        settle(2);
        chk(pins(), 32'h2);
        settle(20);
        press();
        settle(2);
        chk(pins(), 32'h5);
    endtask

    task automatic t_mgmt();
        wr(8'h0c, 32'h7);
        wr(8'h04, 32'h3);
        press();
        expect_msgs(8'h01);
        chk({24'h0, lastCode}, 32'h1);
        rd(8'h04, d);
        chk(d, 32'h1);
        press();
        settle(15);
        chk({24'h0, msgCount}, 32'h1);
        wr(8'h04, 32'h3);
        expect_msgs(8'h02);
        wr(8'h08, 32'h7);
        wr(8'h04, 32'h3);
        settle(15);
        chk({24'h0, msgCount}, 32'h2);
        battery_low_in_n <= 1'b0;
        expect_msgs(8'h03);
        battery_low_in_n <= 1'b1;
        wr(8'h08, 32'h7);
    endtask

    task automatic t_sci();
        logic [31:0] cfg[8] = '{32'h9, 32'ha, 32'hb, 32'h114, 32'h115, 32'h116, 32'h117, 32'h14};
        wr(8'h04, 32'h6);
        for (int i = 0; i < 8; i++) begin
            wr(8'h10, cfg[i]);
            wr(8'h00, 32'h4);
            settle(4);
            chk({8'h0, sciIrqLines}, i < 7 ? 32'h1 << cfg[i][4:0] : 32'h0);
            wr(8'h08, 32'h4);
            settle(2);
            chk({8'h0, sciIrqLines}, 32'h0);
        end
        wr(8'h10, 32'h209);
        settle(2);
        chk({8'h0, sciIrqLines}, 32'h200);
        wr(8'h00, 32'h4);
        settle(2);
        chk({8'h0, sciIrqLines}, 32'h0);
        chk({24'h0, msgCount}, 32'h3);
        wr(8'h08, 32'h4);
    endtask

    task automatic t_pg();
        @(posedge mclk);
        #2 core_power_good = 1'b0;
        #1 chk({31'h0, platform_reset_out_n}, 32'h0);
        @(posedge mclk);
        core_power_good <= 1'b1;
        settle(2);
        chk({31'h0, platform_reset_out_n}, 32'h1);
    endtask

    // A write made while the clock enable is low must leave the enables untouched
    task automatic t_ce();
        ce <= 1'b0;
        wr(8'h0c, 32'h0);
        ce <= 1'b1;
        rd(8'h0c, d);
        chk(d, 32'h7);
    endtask

    task automatic close_out();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Power good starts high and clean, as if the rails had long settled; only t_pg pulls it low briefly
    initial begin
        srst             = 1'b1;
        ce               = 1'b1;
        regAddr          = 8'h00;
        regWrData        = 32'h0;
        regWr            = 1'b0;
        regRd            = 1'b0;
        core_power_good  = 1'b1;
        battery_low_in_n = 1'b1;
        powerButtonPress = 1'b0;
        stallCycles      = 4'h3;
        n_fail           = 0;
        checked          = 0;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        t_reset();
        t_sleep();
        t_mgmt();
        t_sci();
        t_pg();
        t_ce();
        close_out();
    end

    // Watchdog well beyond the expected run
    initial begin
        #100000;
        n_fail++;
        close_out();
    end
endmodule

`default_nettype wire
